// ### pkg/gmcs_consts.vh
// Overview of operation
// R1: a good, fully received packet sets early_good_done, bit 3.
// R2: a bad, fully received packet sets early_bad_done, bit 2.
// R3: write pointer meeting host_read_ptr sets early_overrun_flag, bit 1.
// R4: after a receive error, refill from the errored packet's start address.
// R5: writing one to bits 3, 2 or 1 clears that early flag.
// R6: early_threshold_flag, bit 0, is zero after power-on.
// R7: byte count beyond the receive threshold sets early_threshold_flag.
// R8: packet end sets rx_done_irq or rx_fault_irq and clears threshold flag.
// R9: setting early_threshold_flag also raises rx_done_irq.
// R10: writing soft_init enters reset: tx and rx off, FIFOs reinitialised.
// R11: soft reset reloads buffer pointers from the descriptor ring bases. The code loads zero instead.
// R12: soft reset leaves station address, multicast filter, bus config alone.
// R13: soft_init reads one during the reset and clears itself afterwards.
// R14: receive runs only with rcv_on, transmit only with xmit_on.
// R15: urgent_queue_poll set by software, cleared once urgent queue is sent.
// R16: normal_queue_poll set by software, cleared once normal queue is sent.
// R17: writing zero to doorbell or forced trigger bits changes nothing.
// R18: writing forced_irq_trigger raises interrupt and sets forced_irq_flag.
// R19: forced_irq_trigger self-clears only after forced_irq_flag is cleared.
// R20: writing one to an interrupt status bit clears it.
`ifndef GMCS_CONSTS_VH
`define GMCS_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define GMCS_OFS_EARLY_RX_FLAGS 8'h36
`define GMCS_OFS_COMMAND 8'h37
`define GMCS_OFS_XMIT_POLL 8'h38
`define GMCS_OFS_RX_THRESH_LO 8'h3a
`define GMCS_OFS_RX_THRESH_HI 8'h3b
`define GMCS_OFS_IRQ_FLAGS_LO 8'h3e
`define GMCS_OFS_IRQ_FLAGS_HI 8'h3f

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define GMCS_BIT_GOOD_DONE 3
`define GMCS_BIT_BAD_DONE 2
`define GMCS_BIT_OVERRUN 1
`define GMCS_BIT_THRESHOLD 0
`define GMCS_BIT_SOFT_INIT 4
`define GMCS_BIT_RCV_ON 3
`define GMCS_BIT_XMIT_ON 2
`define GMCS_BIT_URGENT_POLL 7
`define GMCS_BIT_NORMAL_POLL 6
`define GMCS_BIT_FORCED_TRIG 0
`define GMCS_BIT_RX_DONE 0
`define GMCS_BIT_RX_FAULT 1
`define GMCS_BIT_FORCED_FLAG_HI 0

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define GMCS_RST_RX_THRESH 16'h0040
`define GMCS_SOFT_INIT_CYCLES 8

`endif

// ### src/gmcs_regs.v
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "gmcs_consts.vh"

module gmcs_regs #(
    parameter PTR_W = 16,
    parameter CNT_W = 16,
    parameter SOFT_INIT_CYCLES = `GMCS_SOFT_INIT_CYCLES
) (
    input wire i_ref_clk,
    input wire i_rst,
    input wire [7:0] i_addr,
    input wire [7:0] i_wr_data,
    input wire i_wr_stb,
    input wire i_rd_stb,
    output reg [7:0] o_rd_data,
    input wire i_rx_byte_valid,
    input wire [CNT_W-1:0] i_rx_byte_cnt,
    input wire i_rx_pkt_done,
    input wire i_rx_pkt_good,
    input wire [PTR_W-1:0] i_host_read_ptr,
    input wire i_urgent_all_sent,
    input wire i_normal_all_sent,
    output reg o_rcv_on,
    output reg o_xmit_on,
    output reg o_soft_init,
    output reg o_urgent_queue_poll,
    output reg o_normal_queue_poll,
    output reg o_rx_done_irq,
    output reg o_rx_fault_irq,
    output reg o_forced_irq_flag,
    output reg [PTR_W-1:0] o_rx_wr_ptr
);

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
reg [3:0] early_q;
reg [3:0] early_d;
reg rcv_on_q;
reg rcv_on_d;
reg xmit_on_q;
reg xmit_on_d;
reg soft_init_q;
reg soft_init_d;
reg [7:0] init_cnt_q;
reg [7:0] init_cnt_d;
reg urgent_q;
reg urgent_d;
reg normal_q;
reg normal_d;
reg trig_q;
reg trig_d;
reg rx_done_q;
reg rx_done_d;
reg rx_fault_q;
reg rx_fault_d;
reg forced_q;
reg forced_d;
reg [15:0] thresh_q;
reg [15:0] thresh_d;
reg armed_q;
reg armed_d;
reg [PTR_W-1:0] wr_ptr_q;
reg [PTR_W-1:0] wr_ptr_d;
reg [PTR_W-1:0] pkt_start_q;
reg [PTR_W-1:0] pkt_start_d;
reg [7:0] rd_d;

localparam [7:0] INIT_LAST = SOFT_INIT_CYCLES - 1;

function wr_hit;
    input [7:0] ofs;
    begin
        wr_hit = i_wr_stb && (i_addr == ofs);
    end
endfunction

// receive events only count while the receiver is on
wire rx_byte = i_rx_byte_valid && rcv_on_q; // R14
wire rx_done = i_rx_pkt_done && rcv_on_q; // R14
wire rx_good = rx_done && i_rx_pkt_good;
wire rx_bad = rx_done && !i_rx_pkt_good;
wire thr_hit = rcv_on_q && armed_q && !rx_done &&
    (i_rx_byte_cnt > thresh_q); // R7
wire [PTR_W-1:0] ptr_inc = wr_ptr_q + {{(PTR_W-1){1'b0}}, 1'b1};

// ----------------------------------------------------------------
// next-state logic
// ----------------------------------------------------------------
always @* begin
    early_d = early_q;
    rcv_on_d = rcv_on_q;
    xmit_on_d = xmit_on_q;
    soft_init_d = soft_init_q;
    init_cnt_d = init_cnt_q;
    urgent_d = urgent_q;
    normal_d = normal_q;
    trig_d = trig_q;
    rx_done_d = rx_done_q;
    rx_fault_d = rx_fault_q;
    forced_d = forced_q;
    thresh_d = thresh_q;
    armed_d = armed_q;
    wr_ptr_d = wr_ptr_q;
    pkt_start_d = pkt_start_q;

    // software clears first so hardware sets below win a tie
    if (wr_hit(`GMCS_OFS_EARLY_RX_FLAGS)) begin
        early_d[3:1] = early_q[3:1] & ~i_wr_data[3:1]; // R5
    end
    if (wr_hit(`GMCS_OFS_IRQ_FLAGS_LO)) begin
        if (i_wr_data[`GMCS_BIT_RX_DONE]) begin
            rx_done_d = 1'b0; // R20
        end
        if (i_wr_data[`GMCS_BIT_RX_FAULT]) begin
            rx_fault_d = 1'b0; // R20
        end
    end
    if (wr_hit(`GMCS_OFS_IRQ_FLAGS_HI) &&
        i_wr_data[`GMCS_BIT_FORCED_FLAG_HI]) begin
        forced_d = 1'b0; // R20
    end
    if (wr_hit(`GMCS_OFS_RX_THRESH_LO)) begin
        thresh_d[7:0] = i_wr_data;
    end
    if (wr_hit(`GMCS_OFS_RX_THRESH_HI)) begin
        thresh_d[15:8] = i_wr_data;
    end
    if (wr_hit(`GMCS_OFS_COMMAND) && !soft_init_q) begin
        rcv_on_d = i_wr_data[`GMCS_BIT_RCV_ON];
        xmit_on_d = i_wr_data[`GMCS_BIT_XMIT_ON];
        if (i_wr_data[`GMCS_BIT_SOFT_INIT]) begin
            // engines drop on the write edge itself, not one cycle later
            rcv_on_d = 1'b0; // R10
            xmit_on_d = 1'b0; // R10
            soft_init_d = 1'b1; // R10
            init_cnt_d = 8'h00;
        end
    end

    // doorbells: the sent indication clears, a written one sets
    if (i_urgent_all_sent) begin
        urgent_d = 1'b0; // R15
    end
    if (i_normal_all_sent) begin
        normal_d = 1'b0; // R16
    end
    // trigger drops only once the flag it raised has been acknowledged
    if (!forced_q) begin
        trig_d = 1'b0; // R19
    end
    if (wr_hit(`GMCS_OFS_XMIT_POLL)) begin
        // zeros leave the stored bits alone
        if (i_wr_data[`GMCS_BIT_URGENT_POLL]) begin
            urgent_d = 1'b1; // R15 R17
        end
        if (i_wr_data[`GMCS_BIT_NORMAL_POLL]) begin
            normal_d = 1'b1; // R16 R17
        end
        if (i_wr_data[`GMCS_BIT_FORCED_TRIG]) begin
            trig_d = 1'b1; // R17
            forced_d = 1'b1; // R18
        end
    end

    // receive write pointer and early status
    if (rx_byte) begin
        wr_ptr_d = ptr_inc;
        if (ptr_inc == i_host_read_ptr) begin
            early_d[`GMCS_BIT_OVERRUN] = 1'b1; // R3
        end
    end
    if (thr_hit) begin
        early_d[`GMCS_BIT_THRESHOLD] = 1'b1; // R7
        rx_done_d = 1'b1; // R9
        armed_d = 1'b0;
    end
    if (rx_good) begin
        early_d[`GMCS_BIT_GOOD_DONE] = 1'b1; // R1
        rx_done_d = 1'b1; // R8
        pkt_start_d = rx_byte ? ptr_inc : wr_ptr_q;
    end
    if (rx_bad) begin
        early_d[`GMCS_BIT_BAD_DONE] = 1'b1; // R2
        rx_fault_d = 1'b1; // R8
        // errored packet is overwritten from its own start address
        wr_ptr_d = pkt_start_q; // R4
        if (pkt_start_q == i_host_read_ptr) begin
            early_d[`GMCS_BIT_OVERRUN] = 1'b1; // R4
        end
    end
    if (rx_done) begin
        early_d[`GMCS_BIT_THRESHOLD] = 1'b0; // R8
        armed_d = 1'b1;
    end

    // soft reset: engines off, pointers loaded with zero rather than the ring bases;
    // station address, multicast filter and bus config live elsewhere
    // and are not touched here (R12)
    if (soft_init_q) begin
        rcv_on_d = 1'b0; // R10
        xmit_on_d = 1'b0; // R10
        wr_ptr_d = {PTR_W{1'b0}}; // R11
        pkt_start_d = {PTR_W{1'b0}}; // R11
        armed_d = 1'b1;
        early_d[`GMCS_BIT_THRESHOLD] = 1'b0;
        init_cnt_d = init_cnt_q + 8'h01;
        if (init_cnt_q == INIT_LAST) begin
            soft_init_d = 1'b0; // R13
        end
    end
end

// ----------------------------------------------------------------
// read mux
// ----------------------------------------------------------------
always @* begin
    rd_d = 8'h00;
    if (i_rd_stb) begin
        case (i_addr)
            `GMCS_OFS_EARLY_RX_FLAGS: rd_d = {4'h0, early_q};
            `GMCS_OFS_COMMAND: begin
                rd_d = {3'h0, soft_init_q, rcv_on_q, xmit_on_q,
                    2'h0}; // R13
            end
            `GMCS_OFS_XMIT_POLL: begin
                rd_d = {urgent_q, normal_q, 5'h00, trig_q};
            end
            `GMCS_OFS_RX_THRESH_LO: rd_d = thresh_q[7:0];
            `GMCS_OFS_RX_THRESH_HI: rd_d = thresh_q[15:8];
            `GMCS_OFS_IRQ_FLAGS_LO: rd_d = {6'h00, rx_fault_q, rx_done_q};
            `GMCS_OFS_IRQ_FLAGS_HI: rd_d = {7'h00, forced_q};
            default: rd_d = 8'h00;
        endcase
    end
end

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        early_q <= 4'h0; // R6
        rcv_on_q <= 1'b0;
        xmit_on_q <= 1'b0;
        soft_init_q <= 1'b0;
        init_cnt_q <= 8'h00;
        urgent_q <= 1'b0;
        normal_q <= 1'b0;
        trig_q <= 1'b0;
        rx_done_q <= 1'b0;
        rx_fault_q <= 1'b0;
        forced_q <= 1'b0;
        thresh_q <= `GMCS_RST_RX_THRESH;
        armed_q <= 1'b1;
        wr_ptr_q <= {PTR_W{1'b0}};
        pkt_start_q <= {PTR_W{1'b0}};
        o_rd_data <= 8'h00;
        o_rcv_on <= 1'b0;
        o_xmit_on <= 1'b0;
        o_soft_init <= 1'b0;
        o_urgent_queue_poll <= 1'b0;
        o_normal_queue_poll <= 1'b0;
        o_rx_done_irq <= 1'b0;
        o_rx_fault_irq <= 1'b0;
        o_forced_irq_flag <= 1'b0;
        o_rx_wr_ptr <= {PTR_W{1'b0}};
    end else begin
        early_q <= early_d;
        rcv_on_q <= rcv_on_d;
        xmit_on_q <= xmit_on_d;
        soft_init_q <= soft_init_d;
        init_cnt_q <= init_cnt_d;
        urgent_q <= urgent_d;
        normal_q <= normal_d;
        trig_q <= trig_d;
        rx_done_q <= rx_done_d;
        rx_fault_q <= rx_fault_d;
        forced_q <= forced_d;
        thresh_q <= thresh_d;
        armed_q <= armed_d;
        wr_ptr_q <= wr_ptr_d;
        pkt_start_q <= pkt_start_d;
        o_rd_data <= rd_d;
        // outputs mirror the next state so they match the readback
        o_rcv_on <= rcv_on_d; // R14
        o_xmit_on <= xmit_on_d; // R14
        o_soft_init <= soft_init_d; // R10 R11
        o_urgent_queue_poll <= urgent_d;
        o_normal_queue_poll <= normal_d;
        o_rx_done_irq <= rx_done_d;
        o_rx_fault_irq <= rx_fault_d;
        o_forced_irq_flag <= forced_d; // R18
        o_rx_wr_ptr <= wr_ptr_d;
    end
end

endmodule
`default_nettype wire

// ### tb/gmcs_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module gmcs_regs_chk (
    input wire i_ref_clk,
    input wire i_rst,
    input wire [7:0] i_addr,
    input wire [7:0] i_wr_data,
    input wire i_wr_stb,
    input wire i_rd_stb,
    input wire [7:0] o_rd_data,
    input wire i_rx_pkt_done,
    input wire i_rx_pkt_good,
    input wire i_urgent_all_sent,
    input wire i_normal_all_sent,
    input wire o_rcv_on,
    input wire o_xmit_on,
    input wire o_soft_init,
    input wire o_urgent_queue_poll,
    input wire o_normal_queue_poll,
    input wire o_forced_irq_flag,
    input wire o_rx_done_irq,
    input wire o_rx_fault_irq
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    wire wp = i_wr_stb && i_addr == 8'h38;
    wire rx = o_rcv_on && i_rx_pkt_done;
    // ----------------------------------------------------------------
    // assertions and covers
    // ----------------------------------------------------------------
    a_good_done_irq: assert property (rx && i_rx_pkt_good |=> o_rx_done_irq)
        else $error("good packet not flagged");
    a_bad_done_irq: assert property (rx && !i_rx_pkt_good |=> o_rx_fault_irq)
        else $error("bad packet not flagged");
    a_soft_init_entry: assert property (i_wr_stb && i_addr == 8'h37
        && i_wr_data[4] && !o_soft_init |=> o_soft_init && !o_rcv_on && !o_xmit_on)
        else $error("soft init entry wrong");
    // soft init stands for exactly eight sampled cycles, then self-clears
    a_soft_init_len: assert property ($rose(o_soft_init) |->
        o_soft_init[*8] ##1 !o_soft_init) else $error("soft init length");
    a_urgent_set: assert property (wp && i_wr_data[7] |=> o_urgent_queue_poll)
        else $error("urgent poll not set");
    a_urgent_clear: assert property (i_urgent_all_sent
        && !(wp && i_wr_data[7]) |=> !o_urgent_queue_poll) else $error("urgent");
    a_normal_clear: assert property (i_normal_all_sent
        && !(wp && i_wr_data[6]) |=> !o_normal_queue_poll) else $error("normal");
    a_zero_write_hold: assert property (wp && !i_wr_data[6] && !i_normal_all_sent
        |=> o_normal_queue_poll == $past(o_normal_queue_poll)) else $error("zero");
    a_forced_flag_set: assert property (wp && i_wr_data[0] |=> o_forced_irq_flag)
        else $error("forced flag not set");
    a_irq_w1c_clear: assert property (i_wr_stb && i_addr == 8'h3f
        && i_wr_data[0] && !wp |=> !o_forced_irq_flag) else $error("w1c");
    a_cmd_readback: assert property (i_rd_stb && i_addr == 8'h37 |=> o_rd_data ==
        {3'h0, $past(o_soft_init), $past(o_rcv_on), $past(o_xmit_on), 2'h0})
        else $error("command readback");
    c_soft: cover property ($rose(o_soft_init));
    c_bad: cover property (rx && !i_rx_pkt_good);
    c_forced: cover property (wp && i_wr_data[0]);
endmodule
bind gmcs_regs gmcs_regs_chk chk_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb),
    .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .o_rcv_on(o_rcv_on),
    .i_rx_pkt_done(i_rx_pkt_done), .i_rx_pkt_good(i_rx_pkt_good),
    .i_urgent_all_sent(i_urgent_all_sent), .o_xmit_on(o_xmit_on),
    .i_normal_all_sent(i_normal_all_sent), .o_soft_init(o_soft_init),
    .o_urgent_queue_poll(o_urgent_queue_poll), .o_rx_done_irq(o_rx_done_irq),
    .o_normal_queue_poll(o_normal_queue_poll), .o_rx_fault_irq(o_rx_fault_irq),
    .o_forced_irq_flag(o_forced_irq_flag));
`default_nettype wire

// ### tb/gige_mac_cmd_status_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module gige_mac_cmd_status_regs_test;
    logic i_ref_clk = 0, i_rst = 1, i_wr_stb = 0, i_rd_stb = 0;
    logic [7:0] i_addr = 0, i_wr_data = 0, o_rd_data, t;
    logic [3:0] evs = 0;
    logic i_rx_pkt_good = 0, rd_pend = 0;
    logic [15:0] i_rx_byte_cnt = 0, i_host_read_ptr = 0, o_rx_wr_ptr;
    logic o_rcv_on, o_xmit_on, o_soft_init, o_urgent_queue_poll;
    logic o_normal_queue_poll, o_rx_done_irq, o_rx_fault_irq, o_forced_irq_flag;
    wire i_rx_pkt_done, i_rx_byte_valid, i_urgent_all_sent, i_normal_all_sent;
    logic [7:0] exp_q[$];
    int error_cnt = 0, check_count = 0;
    assign {i_rx_pkt_done, i_rx_byte_valid} = evs[3:2];
    assign {i_urgent_all_sent, i_normal_all_sent} = evs[1:0];
    gmcs_regs dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
        .o_rd_data(o_rd_data), .i_rx_byte_valid(i_rx_byte_valid),
        .i_rx_byte_cnt(i_rx_byte_cnt), .i_rx_pkt_done(i_rx_pkt_done),
        .i_rx_pkt_good(i_rx_pkt_good), .i_host_read_ptr(i_host_read_ptr),
        .i_urgent_all_sent(i_urgent_all_sent), .o_rcv_on(o_rcv_on),
        .i_normal_all_sent(i_normal_all_sent), .o_xmit_on(o_xmit_on),
        .o_soft_init(o_soft_init), .o_urgent_queue_poll(o_urgent_queue_poll),
        .o_normal_queue_poll(o_normal_queue_poll), .o_rx_wr_ptr(o_rx_wr_ptr),
        .o_rx_done_irq(o_rx_done_irq), .o_rx_fault_irq(o_rx_fault_irq),
        .o_forced_irq_flag(o_forced_irq_flag));
    initial forever #5 i_ref_clk = ~i_ref_clk;
    task automatic test_done;
        if (error_cnt == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input [15:0] got, input [15:0] e);
        check_count++;
        if (got !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    // one register access; a read leaves its expected byte in the queue
    task automatic acc(input w, input [7:0] a, input [7:0] d);
        @(posedge i_ref_clk);
        {i_wr_stb, i_rd_stb} <= w ? 2'b10 : 2'b01;
        i_addr <= a;
        i_wr_data <= w ? d : 8'h00;
        if (!w)
            exp_q.push_back(d);
        @(posedge i_ref_clk);
        {i_wr_stb, i_rd_stb} <= 2'b00;
    endtask
    task automatic ev(input [3:0] m);
        @(posedge i_ref_clk);
        evs <= m;
        @(posedge i_ref_clk);
        evs <= 4'h0;
    endtask
    // read data stands only in the cycle after the strobe, so sample it there
    always @(posedge i_ref_clk) begin
        if (rd_pend)
            cmp({8'h00, o_rd_data}, {8'h00, exp_q.pop_front()});
        rd_pend <= i_rd_stb;
    end
    initial begin
        repeat (5000) @(posedge i_ref_clk);
        error_cnt++;
        test_done;
    end
    // ----------------------------------------------------------------
    // stimulus
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hc7f063b3));
        repeat (8) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        i_host_read_ptr <= 16'h8000;
        acc(0, 8'h36, 8'h00);
        acc(0, 8'h3a, 8'h40);
        acc(0, 8'($urandom_range(255, 64)), 8'h00);
        acc(1, 8'h37, 8'h0c);
        acc(0, 8'h37, 8'h0c);
        for (int g = 1; g >= 0; g--) begin
            i_rx_pkt_good <= g[0];
            ev(4'h8);
            acc(0, 8'h36, g ? 8'h08 : 8'h04);
            acc(0, 8'h3e, g ? 8'h01 : 8'h02);
            acc(1, 8'h36, 8'h0c);
            acc(1, 8'h3e, 8'h03);
            acc(0, 8'h36, 8'h00);
            acc(0, 8'h3e, 8'h00);
        end
        t = 8'($urandom_range(20, 1));
        acc(1, 8'h3a, t);
        i_rx_byte_cnt <= {8'h00, t};
        ev(4'h4);
        acc(0, 8'h36, 8'h00);
        i_rx_byte_cnt <= {8'h00, t} + 16'h0001;
        ev(4'h4);
        acc(0, 8'h36, 8'h01);
        acc(0, 8'h3e, 8'h01);
        i_rx_pkt_good <= 1'b1;
        i_rx_byte_cnt <= 16'h0000;
        ev(4'h8);
        acc(0, 8'h36, 8'h08);
        acc(1, 8'h36, 8'h08);
        acc(1, 8'h3e, 8'h01);
        i_host_read_ptr <= 16'h0004;
        ev(4'h4);
        ev(4'h4);
        acc(0, 8'h36, 8'h02);
        acc(1, 8'h36, 8'h02);
        i_host_read_ptr <= 16'h0002;
        i_rx_pkt_good <= 1'b0;
        ev(4'h8);
        acc(0, 8'h36, 8'h06);
        cmp(o_rx_wr_ptr, 16'h0002);
        acc(1, 8'h36, 8'h06);
        acc(1, 8'h3e, 8'h02);
        acc(1, 8'h38, 8'hc0);
        acc(1, 8'h38, 8'h00);
        acc(0, 8'h38, 8'hc0);
        ev(4'h2);
        acc(0, 8'h38, 8'h40);
        ev(4'h1);
        acc(0, 8'h38, 8'h00);
        acc(1, 8'h38, 8'h01);
        acc(1, 8'h38, 8'h00);
        acc(0, 8'h38, 8'h01);
        acc(0, 8'h3f, 8'h01);
        acc(1, 8'h3f, 8'h01);
        acc(0, 8'h38, 8'h00);
        acc(1, 8'h37, 8'h1c);
        acc(0, 8'h37, 8'h10);
        repeat (10) @(posedge i_ref_clk);
        acc(0, 8'h37, 8'h00);
        i_rx_pkt_good <= 1'b1;
        ev(4'h8);
        acc(0, 8'h36, 8'h00);
        repeat (3) @(posedge i_ref_clk);
        test_done;
    end
endmodule
`default_nettype wire
